// *** pts_stage.sv ***
// Top of the programmable threshold stage: scaling, comparisons, timing, ratios.
// Assumes settings and measurements are stable logic on clk; no register bus.
module pts_stage #(
  parameter int W = pts_pkg::MEAS_W,
  parameter int NCH = pts_pkg::NUM_CH,
  parameter int TICK_CYC = pts_pkg::TICK_CYC,
  parameter int DW = pts_pkg::DLY_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Measurements from the measurement subsystem
  input wire logic [NCH-1:0][W-1:0] meas,
  // Blocking from the blocking matrix
  input wire logic block_in,
  // Per-comparison settings
  input wire logic [1:0] num_sel,
  input wire logic [NCH-1:0][W-1:0] mult,
  input wire logic [NCH-1:0][2:0] cmp_mode,
  input wire logic [NCH-1:0][W-1:0] pickup,
  input wire logic [NCH-1:0][pts_pkg::HYST_W-1:0] hyst,
  input wire logic [NCH-1:0] blk_lim_en,
  input wire logic [NCH-1:0][W-1:0] blk_lim,
  input wire logic [W-1:0] calc_pickup,
  // Stage settings
  input wire logic [DW-1:0] op_delay,
  input wire logic [DW-1:0] rel_delay,
  input wire logic [2:0] node_mode_cfg,
  input wire logic node_mode_allow,
  // Condition
  output logic [1:0] cond,
  output logic start,
  output logic trip,
  output logic blocked,
  output logic [NCH-1:0] cmp_active,
  // Live values
  output logic [DW-1:0] time_remaining,
  output logic signed [DW:0] expected_time,
  output logic [NCH-1:0][W-1:0] scaled,
  output logic [NCH-1:0][W-1:0] ratio,
  output logic [W-1:0] calc_ratio,
  output logic [2:0] node_behaviour_mode,
  output logic node_mode_visible
);
  localparam int VW = 2 * W;
  localparam logic signed [VW-1:0] SC = VW'(pts_pkg::SCALE);
  // Largest reported magnitude, five million in value units
  localparam logic signed [VW-1:0] MAG_LIM = SC * VW'(5000000);

  pts_pkg::pts_cond_type state;
  pts_pkg::pts_cond_type next_state;
  pts_pkg::pts_node_type node_e;

  logic [31:0] tick_cnt;
  logic tick, tick_d;
  logic blk_s;
  logic [DW-1:0] op_cnt, rel_cnt;
  logic [DW-1:0] next_op_cnt, next_rel_cnt, next_remaining;
  logic [NCH-1:0] sel_mask;
  logic [1:0] sel_n;
  logic pick, eff_blk, timing, op_reach, rel_done, holding;
  logic [1:0] rat_idx;
  logic div_run, div_go, div_done;
  logic signed [W-1:0] div_quo;
  logic signed [W-1:0] div_src, div_den;
  logic signed [VW-1:0] div_num;
  logic signed [W-1:0] calc_mag;
  logic signed [W-1:0] next_calc;
  logic [DW-1:0] op_dly_c, rel_dly_c;
  logic [1:0] rat_ch;
  logic go_blk;

  // Program cycle strobe
  assign tick = (tick_cnt == 32'(TICK_CYC - 1));

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tick_cnt <= 32'h0000_0000;
      tick_d <= 1'b0;
    end
    else
    begin
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      tick_d <= tick;
    end
  end

  // Selected comparisons; zero selects one
  assign sel_n = (num_sel == 2'h0) ? 2'h1 : num_sel;

  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      logic signed [VW-1:0] prod;
      logic signed [VW-1:0] next_scaled;
      logic signed [VW-1:0] sat_scaled;
      logic [pts_pkg::HYST_W-1:0] hyst_c;
      assign sel_mask[i] = (i < int'(sel_n));
      assign prod = VW'($signed(meas[i])) * VW'($signed(mult[i]));
      assign next_scaled = prod / SC;
      // Saturate at the reported range rather than wrap
      assign sat_scaled = (next_scaled > MAG_LIM) ? MAG_LIM
        : ((next_scaled < -MAG_LIM) ? -MAG_LIM : next_scaled);
      // Hysteresis above half the level is held at the limit
      assign hyst_c = (hyst[i] > pts_pkg::HYST_MAX) ? pts_pkg::HYST_MAX : hyst[i];

      always_ff @(posedge clk)
      begin
        if (sys_rst)
          scaled[i] <= '0;
        else
          scaled[i] <= sat_scaled[W-1:0];
      end

      // Own pick-up, hysteresis and mode for each comparison
      pts_cmp #(
        .W(W),
        .DEPTH(pts_pkg::DELTA_TICKS)
      ) u_cmp (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(tick),
        .mode(cmp_mode[i]),
        .pickup($signed(pickup[i])),
        .hyst(hyst_c),
        .blk_lim_en(blk_lim_en[i]),
        .blk_lim($signed(blk_lim[i])),
        .value($signed(scaled[i])),
        .active(cmp_active[i])
      );
    end
  endgenerate

  // Stage picks up when every selected comparison holds
  assign pick = &(cmp_active | ~sel_mask);

  // Calculated magnitude is the largest selected scaled value
  always_comb
  begin
    next_calc = $signed(scaled[0]);
    for (int k = 1; k < NCH; k++)
    begin
      if (sel_mask[k] && ($signed(scaled[k]) > next_calc))
        next_calc = $signed(scaled[k]);
    end
  end

  // Ratio sequencer: one divider shared by all ratios
  assign div_go = ~div_run;
  // Index kept in range while the calculated magnitude is divided
  assign rat_ch = (rat_idx == 2'(NCH)) ? 2'h0 : rat_idx;
  assign div_src = (rat_idx == 2'(NCH)) ? calc_mag : $signed(scaled[rat_ch]);
  assign div_den = (rat_idx == 2'(NCH)) ? $signed(calc_pickup) : $signed(pickup[rat_ch]);
  assign div_num = VW'(div_src) * SC;

  pts_div #(
    .W(W),
    .NW(VW)
  ) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .go(div_go),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_quo)
  );

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      div_run <= 1'b0;
      rat_idx <= 2'h0;
      ratio <= '0;
      calc_ratio <= '0;
      calc_mag <= '0;
    end
    else
    begin
      calc_mag <= next_calc;
      if (div_go)
        div_run <= 1'b1;
      else if (div_done)
      begin
        div_run <= 1'b0;
        rat_idx <= (rat_idx == 2'(NCH)) ? 2'h0 : rat_idx + 2'h1;
        if (rat_idx == 2'(NCH))
          calc_ratio <= div_quo;
        else
          ratio[rat_ch] <= div_quo;
      end
    end
  end

  // Operate and release timing
  assign node_e = pts_pkg::pts_node_type'(node_mode_cfg);
  assign eff_blk = blk_s || (node_e == pts_pkg::NODE_BLOCKED)
    || (node_e == pts_pkg::NODE_TEST_BLOCKED);
  assign timing = pick && !eff_blk && (node_e != pts_pkg::NODE_OFF);
  assign go_blk = pick && eff_blk && (node_e != pts_pkg::NODE_OFF);
  // Delays beyond 1800 s are held at the limit
  assign op_dly_c = (op_delay > DW'(pts_pkg::DLY_MAX)) ? DW'(pts_pkg::DLY_MAX)
    : op_delay;
  assign rel_dly_c = (rel_delay > DW'(pts_pkg::DLY_MAX)) ? DW'(pts_pkg::DLY_MAX)
    : rel_delay;
  assign op_reach = (op_cnt + DW'(1)) >= op_dly_c;
  assign holding = (op_cnt != '0) || (state == pts_pkg::COND_TRIP);
  assign rel_done = (rel_cnt + DW'(1)) >= rel_dly_c;
  // Pick-up back inside the release delay resumes from the held count
  assign next_op_cnt = timing ? (op_reach ? op_dly_c : op_cnt + DW'(1))
    : ((holding && rel_done) ? '0 : op_cnt);
  assign next_rel_cnt = (timing || !holding || rel_done) ? '0 : rel_cnt + DW'(1);
  assign next_remaining = (next_state == pts_pkg::COND_START) ? op_dly_c - next_op_cnt
    : '0;

  always_comb
  begin
    next_state = pts_pkg::COND_NORMAL;
    case (state)
      pts_pkg::COND_TRIP:
      begin
        // Trip holds while pick-up stays unblocked
        if (go_blk)
          next_state = pts_pkg::COND_BLOCKED;
        else if (timing && op_reach)
          next_state = pts_pkg::COND_TRIP;
        else if (timing)
          next_state = pts_pkg::COND_START;
      end
      pts_pkg::COND_BLOCKED:
      begin
        // Release of blocking resumes timing from the held count
        if (go_blk)
          next_state = pts_pkg::COND_BLOCKED;
        else if (timing && op_reach)
          next_state = pts_pkg::COND_TRIP;
        else if (timing)
          next_state = pts_pkg::COND_START;
      end
      default:
      begin
        // Normal and start: blocking wins over timing
        if (go_blk)
          next_state = pts_pkg::COND_BLOCKED;
        else if (timing && op_reach)
          next_state = pts_pkg::COND_TRIP;
        else if (timing)
          next_state = pts_pkg::COND_START;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      blk_s <= 1'b0;
      state <= pts_pkg::COND_NORMAL;
      op_cnt <= '0;
      rel_cnt <= '0;
      time_remaining <= '0;
    end
    else
    begin
      if (tick)
        blk_s <= block_in;
      if (tick_d)
      begin
        state <= next_state;
        op_cnt <= next_op_cnt;
        rel_cnt <= next_rel_cnt;
        time_remaining <= next_remaining;
      end
    end
  end

  // Reported expected time and mode
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      expected_time <= '0;
      node_behaviour_mode <= 3'h0;
      node_mode_visible <= 1'b0;
    end
    else
    begin
      expected_time <= $signed({1'b0, op_delay});
      node_behaviour_mode <= node_mode_allow ? node_mode_cfg : 3'h0;
      node_mode_visible <= node_mode_allow;
    end
  end

  assign cond = state;
  assign start = (state == pts_pkg::COND_START);
  assign trip = (state == pts_pkg::COND_TRIP) && (node_e == pts_pkg::NODE_ON);
  assign blocked = (state == pts_pkg::COND_BLOCKED);
endmodule

// *** pts_pkg.sv ***
// Shared constants and types for the programmable threshold stage.
// Assumes values arrive as signed integers in units of 0.0001 on one 250 MHz clock.
// Contract
// - One to three measurements, each compared against its own pick-up level.
// - Each measurement is scaled by a multiplier; 1.0 passes it unchanged; result readable.
// - Ratio of each magnitude and the calculated magnitude to its setting, always live.
// - Release hysteresis relative to pick-up, 0 to 50 percent, default 3 percent.
// - Eight comparator modes per magnitude, default is above.
// - Above: signed scaled value greater than pick-up.
// - Absolute above: absolute scaled value greater than pick-up.
// - Below: signed scaled value less than pick-up.
// - Absolute below: absolute scaled value less than pick-up.
// - Below modes: optional blocking limit forces the condition false under it.
// - Relative signed change above set percent within 20 ms, direction counts.
// - Relative absolute change above set percent within 20 ms, either direction.
// - Signed change above pick-up amount within 20 ms, direction counts.
// - Absolute change above pick-up amount within 20 ms, either direction.
// - Pick-up is signed, resolution 0.0001, default 0.01.
// - Pick-up and hysteresis are held per comparison.
// - Operate and release delays up to 1800 s in 5 ms steps, 40/60 ms default.
// - Condition reported as normal, start, trip or blocked.
// - Remaining time to trip counts down while timing toward trip.
// - Expected operating time is reported.
// - Node behaviour mode reported, visible only when individual setting is allowed.
// - Blocking sampled each cycle; clear gives start, set gives blocked.
// - Blocking during start drops start and runs the release delay.
package pts_pkg;
  localparam int MEAS_W = 40;
  localparam int NUM_CH = 3;
  localparam longint SCALE = 64'sd10000;
  localparam logic [39:0] MULT_RST = 40'h00_0000_2710;
  localparam logic [39:0] PICKUP_RST = 40'h00_0000_0064;
  localparam int HYST_W = 20;
  localparam logic [19:0] HYST_RST = 20'h07530;
  localparam logic [19:0] HYST_MAX = 20'h7a120;
  localparam longint HYST_DEN = 64'sd1000000;
  localparam longint PCT_DEN = 64'sd1000000;
  localparam int CLK_NS = 4;
  localparam int STEP_MS = 5;
  localparam int TICK_CYC = STEP_MS * 1000000 / CLK_NS;
  localparam int DELTA_MS = 20;
  localparam int DELTA_TICKS = DELTA_MS / STEP_MS;
  localparam int BLK_LEAD_MS = 5;
  localparam int DLY_W = 19;
  localparam int OP_DLY_MS = 40;
  localparam int REL_DLY_MS = 60;
  localparam int DLY_MAX_MS = 1800000;
  localparam logic [18:0] OP_DLY_RST = 19'(OP_DLY_MS / STEP_MS);
  localparam logic [18:0] REL_DLY_RST = 19'(REL_DLY_MS / STEP_MS);
  localparam logic [18:0] DLY_MAX = 19'(DLY_MAX_MS / STEP_MS);

  typedef enum logic [2:0] {
    CMP_ABOVE, CMP_ABS_ABOVE, CMP_BELOW, CMP_ABS_BELOW,
    CMP_REL_SIGNED, CMP_REL_ABS, CMP_DELTA_SIGNED, CMP_DELTA_ABS
  } pts_cmp_type;

  typedef enum logic [1:0] {
    COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED
  } pts_cond_type;

  typedef enum logic [2:0] {
    NODE_ON, NODE_BLOCKED, NODE_TEST, NODE_TEST_BLOCKED, NODE_OFF
  } pts_node_type;
endpackage

// *** pts_cmp.sv ***
// One comparison channel: mode select, hysteresis latch and 20 ms history.
// Assumes tick pulses once per program cycle and value is already scaled.
module pts_cmp #(
  parameter int W = pts_pkg::MEAS_W,
  parameter int DEPTH = pts_pkg::DELTA_TICKS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Program cycle strobe
  input wire logic tick,
  // Settings of this comparison
  input wire logic [2:0] mode,
  input wire logic signed [W-1:0] pickup,
  input wire logic [pts_pkg::HYST_W-1:0] hyst,
  input wire logic blk_lim_en,
  input wire logic signed [W-1:0] blk_lim,
  // Measurement and result
  input wire logic signed [W-1:0] value,
  output logic active
);
  localparam int VW = 2 * W;
  localparam logic signed [VW-1:0] PCT = VW'(pts_pkg::PCT_DEN);
  localparam logic signed [VW-1:0] HDEN = VW'(pts_pkg::HYST_DEN);

  logic [DEPTH-1:0][W-1:0] hist;
  pts_pkg::pts_cmp_type mode_e;
  logic signed [VW-1:0] x, xo, p, d, hy;
  logic signed [VW-1:0] absx, absd, absold, absp, rel_t, abs_rel;
  logic signed [VW-1:0] v, t, abst, h;
  logic over, set_c, clr_c, below_mode, inhibit, next_active;

  assign mode_e = pts_pkg::pts_cmp_type'(mode);
  assign x = VW'(value);
  assign xo = VW'($signed(hist[DEPTH-1]));
  assign p = VW'(pickup);
  assign hy = VW'(hyst);
  assign d = x - xo;
  assign absx = (x < 0) ? -x : x;
  assign absd = (d < 0) ? -d : d;
  assign absold = (xo < 0) ? -xo : xo;
  assign absp = (p < 0) ? -p : p;
  // Percent threshold taken from the value one window ago
  assign rel_t = (absold * p) / PCT;
  assign abs_rel = (rel_t < 0) ? -rel_t : rel_t;

  always_comb
  begin
    v = x;
    t = p;
    over = 1'b1;
    case (mode_e)
      pts_pkg::CMP_ABOVE:
      begin
        v = x;
        t = p;
        over = 1'b1;
      end
      pts_pkg::CMP_ABS_ABOVE:
      begin
        v = absx;
        t = p;
        over = 1'b1;
      end
      pts_pkg::CMP_BELOW:
      begin
        v = x;
        t = p;
        over = 1'b0;
      end
      pts_pkg::CMP_ABS_BELOW:
      begin
        v = absx;
        t = p;
        over = 1'b0;
      end
      pts_pkg::CMP_REL_SIGNED:
      begin
        v = d;
        t = rel_t;
        over = ~p[VW-1];
      end
      pts_pkg::CMP_REL_ABS:
      begin
        v = absd;
        t = abs_rel;
        over = 1'b1;
      end
      pts_pkg::CMP_DELTA_SIGNED:
      begin
        v = d;
        t = p;
        over = ~p[VW-1];
      end
      default:
      begin
        v = absd;
        t = absp;
        over = 1'b1;
      end
    endcase
  end

  assign abst = (t < 0) ? -t : t;
  assign h = (abst * hy) / HDEN;
  assign set_c = over ? (v > t) : (v < t);
  assign clr_c = over ? (v < t - h) : (v > t + h);
  assign below_mode = (mode_e == pts_pkg::CMP_BELOW) || (mode_e == pts_pkg::CMP_ABS_BELOW);
  assign inhibit = below_mode && blk_lim_en && (value < blk_lim);
  assign next_active = inhibit ? 1'b0 : (active ? ~clr_c : set_c);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      hist <= '0;
      active <= 1'b0;
    end
    else if (tick)
    begin
      hist <= {hist[DEPTH-2:0], value};
      active <= next_active;
    end
  end
endmodule

// *** pts_div.sv ***
// Serial signed divider for magnitude-to-setting ratios.
// Assumes go is only raised while no division runs; a zero divisor saturates.
module pts_div #(
  parameter int W = pts_pkg::MEAS_W,
  parameter int NW = 2 * pts_pkg::MEAS_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request
  input wire logic go,
  input wire logic signed [NW-1:0] num,
  input wire logic signed [W-1:0] den,
  // Answer
  output logic done,
  output logic signed [W-1:0] quo
);
  logic busy, neg, dz;
  logic [7:0] cnt;
  logic [W:0] rem;
  logic [W-1:0] dmag;
  logic [NW-1:0] q;
  logic [W:0] shifted;
  logic ge;
  logic [W:0] next_rem;
  logic [NW-1:0] next_q;
  logic ovf;
  logic [W-1:0] mag;
  logic signed [W-1:0] next_quo;

  assign shifted = {rem[W-1:0], q[NW-1]};
  assign ge = shifted >= {1'b0, dmag};
  assign next_rem = ge ? shifted - {1'b0, dmag} : shifted;
  assign next_q = {q[NW-2:0], ge};
  assign ovf = dz || (next_q[NW-1:W-1] != '0);
  assign mag = ovf ? {1'b0, {(W-1){1'b1}}} : next_q[W-1:0];
  assign next_quo = neg ? -$signed(mag) : $signed(mag);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busy <= 1'b0;
      neg <= 1'b0;
      dz <= 1'b0;
      cnt <= 8'h00;
      rem <= '0;
      dmag <= '0;
      q <= '0;
      done <= 1'b0;
      quo <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (go && !busy)
      begin
        busy <= 1'b1;
        cnt <= 8'h00;
        rem <= '0;
        q <= num[NW-1] ? -num : num;
        dmag <= den[W-1] ? -den : den;
        neg <= num[NW-1] ^ den[W-1];
        dz <= (den == '0);
      end
      else if (busy)
      begin
        rem <= next_rem;
        q <= next_q;
        cnt <= cnt + 8'h01;
        if (cnt == 8'(NW - 1))
        begin
          busy <= 1'b0;
          done <= 1'b1;
          quo <= next_quo;
        end
      end
    end
  end
endmodule

// *** pts_stage_sva.sv ***
// Checker for the threshold stage, watching only the top-level ports.
// Assumes one clock domain and a synchronous active-high reset.
module pts_stage_chk #(
  parameter int W = 40,
  parameter int NCH = 3,
  parameter int TICK_CYC = 8,
  parameter int DW = 19
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watched inputs
  input wire logic [NCH-1:0][W-1:0] meas,
  input wire logic block_in,
  input wire logic [NCH-1:0][W-1:0] mult,
  input wire logic [DW-1:0] op_delay,
  input wire logic [2:0] node_mode_cfg,
  input wire logic node_mode_allow,
  // Watched outputs
  input wire logic [1:0] cond,
  input wire logic start,
  input wire logic trip,
  input wire logic blocked,
  input wire logic [NCH-1:0] cmp_active,
  input wire logic [DW-1:0] time_remaining,
  input wire logic signed [DW:0] expected_time,
  input wire logic [NCH-1:0][W-1:0] scaled,
  input wire logic [2:0] node_behaviour_mode,
  input wire logic node_mode_visible
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] blk_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Length of the current run of blocking
  always_ff @(posedge clk)
  begin
    if (sys_rst || !block_in) blk_cnt <= 16'h0000;
    else if (blk_cnt != 16'hffff) blk_cnt <= blk_cnt + 16'h0001;
  end
  property p_rst_out;
    $fell(sys_rst) |-> cond == 2'h0 && !start && !trip && !blocked;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not clear after reset");
  property p_start_dec;
    start == (cond == pts_pkg::COND_START);
  endproperty
  a_start_dec: assert property (p_start_dec)
    else $error("start does not match condition");
  property p_blk_dec;
    blocked == (cond == pts_pkg::COND_BLOCKED);
  endproperty
  a_blk_dec: assert property (p_blk_dec)
    else $error("blocked does not match condition");
  property p_trip_dec;
    trip |-> cond == pts_pkg::COND_TRIP;
  endproperty
  a_trip_dec: assert property (p_trip_dec)
    else $error("trip outside trip condition");
  property p_remain;
    cond != pts_pkg::COND_START && $past(cond) != pts_pkg::COND_START |-> time_remaining == 0;
  endproperty
  a_remain: assert property (p_remain)
    else $error("time remaining nonzero outside start");
  property p_expect;
    !$past(sys_rst) && !$past(sys_rst, 2) |-> expected_time == $past(op_delay);
  endproperty
  a_expect: assert property (p_expect)
    else $error("expected time differs from operate delay");
  property p_node;
    !$past(sys_rst) && !$past(sys_rst, 2) |-> node_mode_visible == $past(node_mode_allow)
      && node_behaviour_mode == ($past(node_mode_allow) ? $past(node_mode_cfg) : 3'h0);
  endproperty
  a_node: assert property (p_node)
    else $error("node behaviour mode wrong");
  property p_scale;
    !$past(sys_rst) && !$past(sys_rst, 2) && $past(mult[0]) == pts_pkg::MULT_RST
      |-> scaled[0] == $past(meas[0]);
  endproperty
  a_scale: assert property (p_scale)
    else $error("unit multiplier changed the value");
  property p_start_cause;
    $rose(start) |-> $past(cmp_active[0]);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start without pick-up");
  property p_block;
    blk_cnt > TICK_CYC + 2 |-> !start && !trip;
  endproperty
  a_block: assert property (p_block)
    else $error("start or trip while blocked");
  c_start: cover property (start);
  c_trip: cover property (trip);
  c_blocked: cover property (blocked);
endmodule

bind pts_stage pts_stage_chk #(.W(W), .NCH(NCH), .TICK_CYC(TICK_CYC), .DW(DW)) pts_stage_chk_inst (
  .clk(clk), .sys_rst(sys_rst), .meas(meas), .block_in(block_in), .mult(mult),
  .op_delay(op_delay), .node_mode_cfg(node_mode_cfg), .node_mode_allow(node_mode_allow),
  .cond(cond), .start(start), .trip(trip), .blocked(blocked), .cmp_active(cmp_active),
  .time_remaining(time_remaining), .expected_time(expected_time), .scaled(scaled),
  .node_behaviour_mode(node_behaviour_mode), .node_mode_visible(node_mode_visible));

// *** pts_meas_src.sv ***
// Model of the measurement subsystem and blocking matrix feeding the stage.
// Assumes the bench posts requested values; outputs change just after a clock edge.
module pts_meas_src
(
  // Clock
  input wire logic clk,
  // Requested values
  input wire logic [2:0][39:0] want_meas,
  input wire logic want_block,
  // Toward the stage
  output logic [2:0][39:0] meas,
  output logic block_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    meas = '0;
    block_in = 1'b0;
  end
  // Requested measurements and blocking are passed on one clock later, as given
  always @(posedge clk)
  begin
    meas <= want_meas;
    block_in <= want_block;
  end
endmodule

// *** tb.sv ***
// Self-checking bench for the programmable threshold stage.
// Assumes a program cycle shortened to eight clocks.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0][39:0] want_meas = '0;
  logic want_block = 1'b0;
  logic [2:0][39:0] meas;
  logic block_in;
  logic [1:0] num_sel = 2'h1;
  logic [2:0][39:0] mult = {3{pts_pkg::MULT_RST}};
  logic [2:0][2:0] cmp_mode = '0;
  logic [2:0][39:0] pickup = {3{pts_pkg::PICKUP_RST}};
  logic [2:0][19:0] hyst = {3{pts_pkg::HYST_RST}};
  logic [2:0] blk_lim_en = '0;
  logic [2:0][39:0] blk_lim = '0;
  logic [39:0] calc_pickup = pts_pkg::PICKUP_RST;
  logic [18:0] op_delay = pts_pkg::OP_DLY_RST;
  logic [18:0] rel_delay = pts_pkg::REL_DLY_RST;
  logic [2:0] node_mode_cfg = 3'h0;
  logic node_mode_allow = 1'b0;
  logic [1:0] cond;
  logic start, trip, blocked;
  logic [2:0] cmp_active;
  logic [18:0] time_remaining;
  logic signed [19:0] expected_time;
  logic [2:0][39:0] scaled, ratio;
  logic [39:0] calc_ratio;
  logic [2:0] node_behaviour_mode;
  logic node_mode_visible;
  int num_errors = 0;
  int checks_done = 0;
  int n;
  // Mode, pick-up, start value, final value, limit enable, expected result
  int t_m [11] = '{0, 1, 2, 3, 2, 4, 5, 6, 7, 3, 0};
  int t_pu [11] = '{100, 100, 100, 100, 100, 100000, 100000, 100, 100, 100, -100};
  int t_v0 [11] = '{0, 0, 0, 0, 0, 10000, 10000, 1000, 1000, 0, -200};
  int t_v1 [11] = '{150, -150, -150, -150, -50, 12000, 8000, 900, 850, 50, -50};
  int t_le [11] = '{0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0};
  int t_ex [11] = '{1, 1, 1, 0, 0, 1, 1, 0, 1, 1, 1};

  always #2 clk = ~clk;

  pts_meas_src pts_meas_src_inst (.clk(clk), .want_meas(want_meas), .want_block(want_block),
    .meas(meas), .block_in(block_in));

  pts_stage #(.TICK_CYC(TK)) pts_stage_inst (.clk(clk), .sys_rst(sys_rst), .meas(meas),
    .block_in(block_in), .num_sel(num_sel), .mult(mult), .cmp_mode(cmp_mode),
    .pickup(pickup), .hyst(hyst), .blk_lim_en(blk_lim_en), .blk_lim(blk_lim),
    .calc_pickup(calc_pickup), .op_delay(op_delay), .rel_delay(rel_delay),
    .node_mode_cfg(node_mode_cfg), .node_mode_allow(node_mode_allow), .cond(cond),
    .start(start), .trip(trip), .blocked(blocked), .cmp_active(cmp_active),
    .time_remaining(time_remaining), .expected_time(expected_time), .scaled(scaled),
    .ratio(ratio), .calc_ratio(calc_ratio), .node_behaviour_mode(node_behaviour_mode),
    .node_mode_visible(node_mode_visible));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tk(input int t);
    repeat (t * TK) @(posedge clk);
    #1;
  endtask

  task automatic put(input int ch, input logic [39:0] v);
    @(posedge clk);
    want_meas[ch] <= v;
  endtask

  task automatic rst();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  // Waits a bounded time for a condition and counts the cycles taken
  task automatic wait_cond(input logic [1:0] v);
    n = 0;
    while (cond !== v && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(cond, v);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("FAIL %0t watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    rst();
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk);
      cmp_mode[0] <= 3'(t_m[i]);
      pickup[0] <= 40'(t_pu[i]);
      blk_lim_en[0] <= t_le[i][0];
      rst();
      put(0, 40'(t_v0[i]));
      tk(6);
      put(0, 40'(t_v1[i]));
      tk(2);
      chk(cmp_active[0], t_ex[i]);
    end
    @(posedge clk);
    cmp_mode[0] <= 3'h0;
    pickup[0] <= 40'h00_0000_0064;
    blk_lim_en[0] <= 1'b0;
    rst();
    put(0, 40'h00_0000_0032);
    tk(1);
    chk(scaled[0], 64'h32);
    @(posedge clk);
    mult[0] <= 40'h00_0000_4e20;
    tk(1);
    chk(scaled[0], 64'h64);
    @(posedge clk);
    mult[0] <= pts_pkg::MULT_RST;
    put(0, 40'h00_0000_0096);
    wait_cond(pts_pkg::COND_START);
    repeat (2) @(posedge clk);
    #1;
    chk(time_remaining, 64'h7);
    chk(expected_time, 64'h8);
    wait_cond(pts_pkg::COND_TRIP);
    chk(n >= 6 * TK && n <= 8 * TK, 1);
    chk(trip, 1);
    tk(45);
    chk(ratio[0], 64'h3a98);
    chk(calc_ratio, 64'h3a98);
    put(0, 40'h00_0000_0062);
    tk(3);
    chk(cmp_active[0], 1);
    put(0, 40'h00_0000_0060);
    tk(2);
    chk(cmp_active[0], 0);
    wait_cond(pts_pkg::COND_NORMAL);
    // Let the release delay clear the held operate count
    tk(13);
    @(posedge clk);
    num_sel <= 2'h2;
    put(0, 40'h00_0000_0096);
    tk(4);
    chk(start, 0);
    put(1, 40'h00_0000_0096);
    wait_cond(pts_pkg::COND_START);
    @(posedge clk);
    want_block <= 1'b1;
    wait_cond(pts_pkg::COND_BLOCKED);
    chk(blocked, 1);
    chk(start, 0);
    @(posedge clk);
    want_block <= 1'b0;
    wait_cond(pts_pkg::COND_START);
    @(posedge clk);
    node_mode_allow <= 1'b1;
    node_mode_cfg <= 3'h2;
    tk(1);
    chk(node_behaviour_mode, 64'h2);
    @(posedge clk);
    node_mode_cfg <= 3'h4;
    tk(2);
    chk(cond, pts_pkg::COND_NORMAL);
    tk(42);
    chk(ratio[1], 64'h3a98);
    end_sim();
  end
endmodule
